//--- design/i2c_mode_irq_pkg.sv
package i2c_mode_irq_pkg;

    // ==========================================================
    // Register indices and byte addresses
    // ==========================================================
    localparam logic [31:0] TRANSFER_MODE_INDEX    = 32'h00FF_05CA;
    localparam logic [31:0] INTERRUPT_ENABLE_INDEX = 32'h00FF_05CB;
    localparam logic [31:0] LINK_CONTROL_INDEX     = 32'h00FF_05D0;
    localparam logic [31:0] TRANSFER_MODE_ADDR     = {TRANSFER_MODE_INDEX[29:0], 2'b00};
    localparam logic [31:0] INTERRUPT_ENABLE_ADDR  = {INTERRUPT_ENABLE_INDEX[29:0], 2'b00};
    localparam logic [31:0] LINK_CONTROL_ADDR      = {LINK_CONTROL_INDEX[29:0], 2'b00};

    // ==========================================================
    // Transfer mode fields
    // ==========================================================
    localparam int BIT_ORDER_POS   = 7;
    localparam int WAIT_POS        = 6;
    localparam int RSVD_ZERO_POS   = 5;
    localparam int RSVD_ONE_POS    = 4;
    localparam int WRITE_PROT_POS  = 3;
    localparam int COUNT_MSB       = 2;
    localparam logic       BIT_ORDER_RST  = 1'b0;
    localparam logic       WAIT_RST       = 1'b0;
    localparam logic       WRITE_PROT_RST = 1'b1;
    localparam logic [2:0] COUNT_RST      = 3'h0;

    // ==========================================================
    // Interrupt enable fields
    // ==========================================================
    localparam int TX_EMPTY_EN_POS  = 7;
    localparam int TX_END_EN_POS    = 6;
    localparam int RX_FULL_EN_POS   = 5;
    localparam int NO_ACK_EN_POS    = 4;
    localparam int STOP_EN_POS      = 3;
    localparam int ACK_JUDGE_POS    = 2;
    localparam int ACK_RECV_POS     = 1;
    localparam int ACK_SEND_POS     = 0;
    localparam logic [7:0] ENABLE_RST = 8'h00;

    // ==========================================================
    // Link control fields
    // ==========================================================
    localparam int MASTER_POS      = 0;
    localparam int SYNC_FMT_POS    = 1;
    localparam int TRANSMIT_POS    = 2;
    localparam int STOPPED_POS     = 6;
    localparam int ACTIVE_POS      = 7;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int PCLK_PERIOD_NS    = 50;
    localparam int TRANSFER_CLK_NS   = 400;
    localparam int WAIT_CLOCKS       = 2;
    localparam int WAIT_CYCLES       = (WAIT_CLOCKS * TRANSFER_CLK_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
    localparam logic [4:0] WAIT_CNT  = WAIT_CYCLES[4:0];
    localparam logic [3:0] NINTH_BIT = 4'h9;

    // Frame length for a count code
    function automatic logic [3:0] frame_length(input logic [2:0] code, input logic sync_fmt);
        logic [3:0] len;
        len = {1'b0, code};
        if (sync_fmt) begin
            frame_length = (code == 3'h0) ? 4'h8 : len;
        end else begin
            frame_length = len + 4'h1 + ((code == 3'h0) ? 4'h8 : 4'h0);
        end
    endfunction

endpackage

//--- design/i2c_mode_irq.sv
`timescale 1ns/100ps
// Operation
// - Master wait holds SCL low two clocks
// - Wait off: data and ack back-to-back
// - Wait ignored in slave or synchronous format
// - Count written only when protect bit zero
// - Count code maps to frame length
// - Count reads remaining bits, counting down
// - I2C frame includes one acknowledge bit
// - Count returns to zero at frame end
// - Transmit-empty request is flag AND enable
// - Transmit-end raised at ninth SCL rise
// - Transmit-end request drops with flag or enable
// - Receive-full enable gates receive request
// - One enable gates no-ack and overrun requests
// - Stop-detect enable gates stop request
// - Ack judgement stops transfer on NACK
// - Received acknowledge captured in read-only bit
// - Receive mode drives send-ack bit on SDA
// - Reserved mode bits read zero and one
// - Receive request cancelled by flag or enable
// - No-ack flag set on NACK with judgement
module i2c_mode_irq
    import i2c_mode_irq_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        tx_empty_flag,
    input  wire logic        tx_done_flag,
    input  wire logic        rx_full_flag,
    input  wire logic        no_ack_flag,
    input  wire logic        overrun_flag,
    input  wire logic        stop_flag,
    output logic             tx_empty_request,
    output logic             tx_end_request,
    output logic             rx_full_request,
    output logic             no_ack_request,
    output logic             overrun_request,
    output logic             stop_detect_request,
    output logic             no_ack_set,
    output logic             tx_end_set,
    output logic             transfer_stopped,
    output logic             bit_order_select
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic        bit_order_select;
        logic        wait_enable;
        logic        count_write_protect;
        logic [2:0]  frame_bit_count;
        logic [7:2]  enables;
        logic        ack_received_bit;
        logic        ack_send_bit;
        logic        master;
        logic        sync_fmt;
        logic        transmit;
        logic [2:0]  scl_sync;
        logic [2:0]  sda_sync;
        logic        scl_level;
        logic        sda_level;
        logic        active;
        logic [3:0]  remain;
        logic [3:0]  bit_num;
        logic [4:0]  wait_cnt;
        logic        scl_oe;
        logic        sda_oe;
        logic        stopped;
        logic        no_ack_set;
        logic        tx_end_set;
        logic [5:0]  requests;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    localparam state_t STATE_RST = '{
        bit_order_select:    BIT_ORDER_RST,
        wait_enable:         WAIT_RST,
        count_write_protect: WRITE_PROT_RST,
        frame_bit_count:     COUNT_RST,
        enables:             ENABLE_RST[7:2],
        ack_received_bit:    ENABLE_RST[ACK_RECV_POS],
        ack_send_bit:        ENABLE_RST[ACK_SEND_POS],
        scl_sync:            3'h7,
        sda_sync:            3'h7,
        scl_level:           1'b1,
        sda_level:           1'b1,
        default:             '0
    };

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        logic        acc;
        logic        wr;
        logic        hit_mode;
        logic        hit_en;
        logic        hit_ctl;
        logic        scl_rise;
        logic        scl_fall;
        logic [3:0]  new_remain;
        logic [31:0] rdata;
        acc        = 1'b0;
        wr         = 1'b0;
        hit_mode   = 1'b0;
        hit_en     = 1'b0;
        hit_ctl    = 1'b0;
        scl_rise   = 1'b0;
        scl_fall   = 1'b0;
        new_remain = 4'h0;
        rdata      = 32'h0000_0000;
        state_nxt  = state_r;

        // Three-stage pin synchronisers; level moves when stages two and three agree
        state_nxt.scl_sync = {state_r.scl_sync[1:0], scl_in};
        state_nxt.sda_sync = {state_r.sda_sync[1:0], sda_in};
        if (state_r.scl_sync[1] == state_r.scl_sync[2]) begin
            state_nxt.scl_level = state_r.scl_sync[2];
        end
        if (state_r.sda_sync[1] == state_r.sda_sync[2]) begin
            state_nxt.sda_level = state_r.sda_sync[2];
        end
        scl_rise = !state_r.scl_level && (state_r.scl_sync[1] == state_r.scl_sync[2]) && state_r.scl_sync[2];
        scl_fall = state_r.scl_level && (state_r.scl_sync[1] == state_r.scl_sync[2]) && !state_r.scl_sync[2];

        state_nxt.no_ack_set = 1'b0;
        state_nxt.tx_end_set = 1'b0;

        // ======================================================
        // Frame bit counter
        // ======================================================
        if (scl_rise) begin
            if (state_r.active) begin
                new_remain = state_r.remain - 4'h1;
            end else begin
                new_remain = frame_length(state_r.frame_bit_count, state_r.sync_fmt) - 4'h1;
            end
            state_nxt.bit_num = state_r.active ? state_r.bit_num + 4'h1 : 4'h1;
            state_nxt.remain  = new_remain;
            state_nxt.active  = (new_remain != 4'h0);
            if (new_remain == 4'h0) begin
                state_nxt.frame_bit_count = 3'h0;
            end else if (state_r.sync_fmt) begin
                state_nxt.frame_bit_count = new_remain[2:0];
            end else begin
                state_nxt.frame_bit_count = new_remain[2:0] - 3'h1;
            end
            // Acknowledge clock rising edge
            if (!state_r.sync_fmt && new_remain == 4'h0) begin
                if (state_r.transmit) begin
                    state_nxt.ack_received_bit = state_r.sda_level;
                    if (state_r.sda_level && state_r.enables[ACK_JUDGE_POS]) begin
                        state_nxt.no_ack_set = 1'b1;
                        state_nxt.stopped    = 1'b1;
                    end
                end
                if (state_nxt.bit_num == NINTH_BIT && tx_empty_flag) begin
                    state_nxt.tx_end_set = 1'b1;
                end
            end
        end

        // ======================================================
        // Acknowledge drive and wait insertion
        // ======================================================
        if (scl_fall) begin
            if (state_r.active && state_r.remain == 4'h1 && !state_r.sync_fmt) begin
                // Open drain: pull low only for a zero acknowledge
                state_nxt.sda_oe = !state_r.transmit && !state_r.ack_send_bit;
                if (state_r.master && state_r.wait_enable) begin
                    state_nxt.wait_cnt = WAIT_CNT;
                    state_nxt.scl_oe   = 1'b1;
                end
            end else begin
                state_nxt.sda_oe = 1'b0;
            end
        end
        // Without a wait the ack clock follows directly
        if (state_r.wait_cnt != 5'h0) begin
            state_nxt.wait_cnt = state_r.wait_cnt - 5'h1;
            state_nxt.scl_oe   = (state_r.wait_cnt != 5'h1);
        end

        // ======================================================
        // APB slave: one wait state, answer registered
        // ======================================================
        acc      = psel && penable && !state_r.pready;
        hit_mode = (paddr == TRANSFER_MODE_ADDR);
        hit_en   = (paddr == INTERRUPT_ENABLE_ADDR);
        hit_ctl  = (paddr == LINK_CONTROL_ADDR);
        wr       = psel && penable && state_r.pready && pwrite;
        state_nxt.pready  = acc;
        state_nxt.pslverr = acc && !(hit_mode || hit_en || hit_ctl);
        if (hit_mode) begin
            rdata[BIT_ORDER_POS]       = state_r.bit_order_select;
            rdata[WAIT_POS]            = state_r.wait_enable;
            rdata[RSVD_ZERO_POS]       = 1'b0;
            rdata[RSVD_ONE_POS]        = 1'b1;
            rdata[WRITE_PROT_POS]      = state_r.count_write_protect;
            rdata[COUNT_MSB:0]         = state_r.frame_bit_count;
        end else if (hit_en) begin
            rdata[7:2]                 = state_r.enables;
            rdata[ACK_RECV_POS]        = state_r.ack_received_bit;
            rdata[ACK_SEND_POS]        = state_r.ack_send_bit;
        end else if (hit_ctl) begin
            rdata[MASTER_POS]          = state_r.master;
            rdata[SYNC_FMT_POS]        = state_r.sync_fmt;
            rdata[TRANSMIT_POS]        = state_r.transmit;
            rdata[STOPPED_POS]         = state_r.stopped;
            rdata[ACTIVE_POS]          = state_r.active;
        end
        state_nxt.prdata = acc ? rdata : 32'h0000_0000;

        if (wr && hit_mode) begin
            state_nxt.bit_order_select    = pwdata[BIT_ORDER_POS];
            state_nxt.wait_enable         = pwdata[WAIT_POS];
            state_nxt.count_write_protect = pwdata[WRITE_PROT_POS];
            if (!pwdata[WRITE_PROT_POS]) begin
                // Software restarts the frame; stale stop is released
                state_nxt.frame_bit_count = pwdata[COUNT_MSB:0];
                state_nxt.active          = 1'b0;
                state_nxt.stopped         = 1'b0;
            end
        end
        if (wr && hit_en) begin
            state_nxt.enables      = pwdata[7:2];
            state_nxt.ack_send_bit = pwdata[ACK_SEND_POS]; // ack_received_bit is read-only
        end
        if (wr && hit_ctl) begin
            state_nxt.master   = pwdata[MASTER_POS];
            state_nxt.sync_fmt = pwdata[SYNC_FMT_POS];
            state_nxt.transmit = pwdata[TRANSMIT_POS];
        end

        // ======================================================
        // Interrupt requests: registered flag AND enable; overrun also needs synchronous format
        // ======================================================
        state_nxt.requests[5] = tx_empty_flag && state_r.enables[TX_EMPTY_EN_POS];
        state_nxt.requests[4] = tx_done_flag && state_r.enables[TX_END_EN_POS];
        state_nxt.requests[3] = rx_full_flag && state_r.enables[RX_FULL_EN_POS];
        state_nxt.requests[2] = no_ack_flag && state_r.enables[NO_ACK_EN_POS];
        state_nxt.requests[1] = overrun_flag && state_r.sync_fmt
                                && state_r.enables[NO_ACK_EN_POS];
        state_nxt.requests[0] = stop_flag && state_r.enables[STOP_EN_POS];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= STATE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Outputs from flip-flops; scl_out and sda_out tied low
    // ==========================================================
    assign prdata              = state_r.prdata;
    assign pready              = state_r.pready;
    assign pslverr             = state_r.pslverr;
    assign scl_out             = 1'b0;
    assign scl_oe              = state_r.scl_oe;
    assign sda_out             = 1'b0;
    assign sda_oe              = state_r.sda_oe;
    assign tx_empty_request    = state_r.requests[5];
    assign tx_end_request      = state_r.requests[4];
    assign rx_full_request     = state_r.requests[3];
    assign no_ack_request      = state_r.requests[2];
    assign overrun_request     = state_r.requests[1];
    assign stop_detect_request = state_r.requests[0];
    assign no_ack_set          = state_r.no_ack_set;
    assign tx_end_set          = state_r.tx_end_set;
    assign transfer_stopped    = state_r.stopped;
    assign bit_order_select    = state_r.bit_order_select;

endmodule

//--- bench/i2c_mode_irq_checker.sv
`timescale 1ns/100ps
module i2c_mode_irq_checker
    import i2c_mode_irq_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        scl_oe,
    input wire logic        sda_oe,
    input wire logic        tx_empty_flag,
    input wire logic        tx_done_flag,
    input wire logic        rx_full_flag,
    input wire logic        no_ack_flag,
    input wire logic        overrun_flag,
    input wire logic        stop_flag,
    input wire logic        tx_empty_request,
    input wire logic        tx_end_request,
    input wire logic        rx_full_request,
    input wire logic        no_ack_request,
    input wire logic        overrun_request,
    input wire logic        stop_detect_request,
    input wire logic        no_ack_set,
    input wire logic        tx_end_set,
    input wire logic        transfer_stopped
);
    // ==========================================================
    // Register shadow, committed at the same edge as the slave
    // ==========================================================
    typedef struct packed {
        logic [7:0] en;
        logic       wait_on;
        logic [2:0] lc;
    } shadow_t;
    shadow_t sh_r;
    shadow_t sh_nxt;
    always_comb begin
        sh_nxt = sh_r;
        if (psel && penable && pready && pwrite) begin
            if (paddr == INTERRUPT_ENABLE_ADDR) sh_nxt.en = pwdata[7:0];
            if (paddr == TRANSFER_MODE_ADDR) sh_nxt.wait_on = pwdata[6];
            if (paddr == LINK_CONTROL_ADDR) sh_nxt.lc = pwdata[2:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_r <= '0;
        end else begin
            sh_r <= sh_nxt;
        end
    end
    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_tx_empty_gate: assert property (tx_empty_request == $past(tx_empty_flag && sh_r.en[7]))
        else $error("tx empty request differs from flag and enable");
    chk_tx_end_gate: assert property (tx_end_request == $past(tx_done_flag && sh_r.en[6]))
        else $error("tx end request differs from flag and enable");
    chk_rx_full_gate: assert property (rx_full_request == $past(rx_full_flag && sh_r.en[5]))
        else $error("rx full request differs from flag and enable");
    chk_no_ack_gate: assert property (no_ack_request == $past(no_ack_flag && sh_r.en[4]))
        else $error("no ack request differs from flag and enable");
    chk_overrun_gate: assert property (overrun_request == $past(overrun_flag && sh_r.en[4] && sh_r.lc[1]))
        else $error("overrun request differs from flag and enable");
    chk_stop_gate: assert property (stop_detect_request == $past(stop_flag && sh_r.en[3]))
        else $error("stop request differs from flag and enable");
    chk_stretch_len: assert property ($rose(scl_oe) |-> scl_oe[*8] ##1 scl_oe[*8] ##1 !scl_oe)
        else $error("clock stretch length wrong");
    chk_wait_off: assert property (!sh_r.wait_on |-> !scl_oe)
        else $error("clock stretched with wait off");
    chk_wait_ignored: assert property ((!sh_r.lc[0] || sh_r.lc[1]) |-> !scl_oe)
        else $error("clock stretched in slave or synchronous mode");
    chk_ack_drive: assert property (sda_oe |-> !sh_r.en[0] && !sh_r.lc[2])
        else $error("data line pulled low outside receive ack zero");
    chk_tx_end_pulse: assert property (tx_end_set |-> $past(tx_empty_flag) ##1 !tx_end_set)
        else $error("tx end pulse without empty flag or too long");
    chk_no_ack_pulse: assert property (no_ack_set |-> sh_r.en[2] && sh_r.lc[2] ##1 !no_ack_set)
        else $error("no ack pulse without judgement");
    chk_stop_judged: assert property ($rose(transfer_stopped) |-> sh_r.en[2])
        else $error("transfer stopped without judgement");
endmodule

bind i2c_mode_irq i2c_mode_irq_checker i2c_mode_irq_checker_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .scl_oe, .sda_oe,
    .tx_empty_flag, .tx_done_flag, .rx_full_flag, .no_ack_flag, .overrun_flag, .stop_flag,
    .tx_empty_request, .tx_end_request, .rx_full_request, .no_ack_request, .overrun_request,
    .stop_detect_request, .no_ack_set, .tx_end_set, .transfer_stopped
);

//--- bench/i2c_link_partner.sv
`timescale 1ns/100ps
module i2c_link_partner (
    input  wire logic scl_line,
    output logic      scl_drv,
    output logic      sda_drv
);
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // Clock held low between frames so count writes are legal
    task automatic park();
        #200;
        scl_drv = 1'b0;
    endtask
    // Waits on the wire, not its own drive, so stretching is honoured
    task automatic clocks(input int n, input logic last);
        // Off the system clock edge, so a rising SCL never races the stretch
        #10;
        for (int i = 1; i <= n; i++) begin
            sda_drv = (i == n) ? last : i[0];
            #200;
            scl_drv = 1'b1;
            wait (scl_line === 1'b1);
            #200;
            scl_drv = 1'b0;
        end
        // Released data line floats back to its pull-up level
        sda_drv = 1'b1;
    endtask
endmodule

//--- bench/i2c_frame_mode_and_irq_enable_bench.sv
`timescale 1ns/100ps
module i2c_frame_mode_and_irq_enable_bench import i2c_mode_irq_pkg::*;;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, scl_oe, sda_oe, scl_drv, sda_drv, no_ack_set, tx_end_set, transfer_stopped;
    logic        bos;
    logic [5:0]  flg = 6'h00;
    logic [5:0]  req;
    wire         scl_line = scl_drv & ~scl_oe;
    wire         sda_line = sda_drv & ~sda_oe;
    int          errors = 0;
    int          comparisons = 0;
    int          n_str = 0;
    int          n_sda = 0;
    int          n_nak = 0;
    int          n_tx_done_flag = 0;
    int          base[4];
    logic [7:0]  ens[4] = '{8'h00, 8'hF8, 8'h50, 8'hA8};
    // lc, mode, enable, ack level, clocks, stretch, ack drive, nack, end pulse
    int          rows[6][9] = '{'{5, 8'h50, 4, 1, 9, 1, 0, 1, 1}, '{5, 8'h10, 0, 1, 9, 0, 0, 0, 1},
                                '{1, 8'h10, 0, 1, 9, 0, 1, 0, 0}, '{1, 8'h10, 1, 1, 9, 0, 0, 0, 0},
                                '{0, 8'h50, 1, 1, 9, 0, 0, 0, 0}, '{7, 8'h50, 0, 1, 8, 0, 0, 0, 0}};

    i2c_mode_irq i2c_mode_irq_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .scl_in(scl_line), .scl_out(), .scl_oe, .sda_in(sda_line), .sda_out(), .sda_oe,
        .tx_empty_flag(flg[5]), .tx_done_flag(flg[4]), .rx_full_flag(flg[3]), .no_ack_flag(flg[2]),
        .overrun_flag(flg[1]), .stop_flag(flg[0]), .tx_empty_request(req[5]), .tx_end_request(req[4]),
        .rx_full_request(req[3]), .no_ack_request(req[2]), .overrun_request(req[1]),
        .stop_detect_request(req[0]), .no_ack_set, .tx_end_set, .transfer_stopped, .bit_order_select(bos)
    );
    i2c_link_partner i2c_link_partner_i (.scl_line, .scl_drv, .sda_drv);

    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        if (scl_oe === 1'b1) n_str <= n_str + 1;
        if (sda_oe === 1'b1) n_sda <= n_sda + 1;
        if (no_ack_set === 1'b1) n_nak <= n_nak + 1;
        if (tx_end_set === 1'b1) n_tx_done_flag <= n_tx_done_flag + 1;
    end

    // ==========================================================
    // Access tasks
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16) chk(0, 1, "no pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
        repeat (2) @(posedge pclk);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, e, "register read");
    endtask
    task automatic link(input int n, input logic last);
        i2c_link_partner_i.clocks(n, last);
        @(posedge pclk);
    endtask
    task automatic conclude();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        logic [31:0] rd;
        logic        err;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        i2c_link_partner_i.park();
        @(posedge pclk);
        rdc(TRANSFER_MODE_ADDR, 32'h18);
        rdc(INTERRUPT_ENABLE_ADDR, 32'h00);
        apb(1'b0, 32'h10, 32'h0, rd, err);
        chk(rd, 32'h0, "unmapped read");
        chk({31'h0, err}, 32'h1, "unmapped error");
        wr(TRANSFER_MODE_ADDR, 32'h9D);
        rdc(TRANSFER_MODE_ADDR, 32'h98);
        chk({31'h0, bos}, 32'h1, "bit order output");
        wr(TRANSFER_MODE_ADDR, 32'h15);
        rdc(TRANSFER_MODE_ADDR, 32'h15);
        chk({31'h0, bos}, 32'h0, "bit order output");
        wr(TRANSFER_MODE_ADDR, 32'h10);
        rdc(TRANSFER_MODE_ADDR, 32'h10);
        wr(INTERRUPT_ENABLE_ADDR, 32'hFF);
        rdc(INTERRUPT_ENABLE_ADDR, 32'hFD);
        wr(LINK_CONTROL_ADDR, 32'h02);
        foreach (ens[k]) begin
            wr(INTERRUPT_ENABLE_ADDR, ens[k]);
            for (int i = 0; i < 6; i++) begin
                flg <= 6'h01 << i;
                repeat (2) @(posedge pclk);
                chk(req, {ens[k][7:4], ens[k][4:3]} & (6'h01 << i), "gated request");
            end
        end
        flg <= 6'h3F;
        wr(INTERRUPT_ENABLE_ADDR, 32'hF8);
        chk(req, 6'h3F, "all requests");
        wr(LINK_CONTROL_ADDR, 32'h00);
        chk(req, 6'h3D, "overrun outside synchronous");
        flg <= 6'h00;
        repeat (2) @(posedge pclk);
        chk(req, 6'h00, "flags cleared");
        flg <= 6'h3F;
        wr(INTERRUPT_ENABLE_ADDR, 32'h00);
        chk(req, 6'h00, "enables cleared");
        foreach (rows[r]) begin
            flg <= {rows[r][8][0], 5'h00};
            wr(TRANSFER_MODE_ADDR, rows[r][1]);
            wr(INTERRUPT_ENABLE_ADDR, rows[r][2]);
            wr(LINK_CONTROL_ADDR, rows[r][0]);
            base = '{n_str, n_sda, n_nak, n_tx_done_flag};
            link(4, 1'b0);
            rdc(TRANSFER_MODE_ADDR, rows[r][1] | 32'h14);
            link(rows[r][4] - 4, rows[r][3][0]);
            rdc(TRANSFER_MODE_ADDR, rows[r][1] | 32'h10);
            chk(n_str - base[0], rows[r][5] * WAIT_CYCLES, "stretch");
            chk(n_sda > base[1], rows[r][6], "ack drive");
            chk(n_nak - base[2], rows[r][7], "nack pulse");
            chk(transfer_stopped, rows[r][7], "stopped");
            chk(n_tx_done_flag - base[3], rows[r][8], "end pulse");
            if (r == 0) rdc(INTERRUPT_ENABLE_ADDR, 32'h06);
        end
        wr(LINK_CONTROL_ADDR, 32'h05);
        wr(TRANSFER_MODE_ADDR, 32'h13);
        link(2, 1'b0);
        rdc(TRANSFER_MODE_ADDR, 32'h11);
        link(2, 1'b0);
        rdc(TRANSFER_MODE_ADDR, 32'h10);
        conclude();
    end
    // Whole run needs about 40 us
    initial begin
        #200_000;
        errors++;
        conclude();
    end
endmodule
